// [rtl/spcfe_pkg.sv]
// shared constants, register map and types of the serial protocol command front end
package spcfe_pkg;

  // nibble framing
  localparam int          NIB_W    = 4;
  localparam logic [1:0]  NIB_LAST = 2'h3;   // bit count of the last bit of a nibble

  // operation field codes
  localparam logic [1:0]  OP_READ  = 2'h0;
  localparam logic [1:0]  OP_BAD   = 2'h1;
  localparam logic [1:0]  OP_REUSE = 2'h2;
  localparam logic [1:0]  OP_WRITE = 2'h3;

  // protocol field codes
  localparam logic [1:0]  PR_UART  = 2'h0;
  localparam logic [1:0]  PR_SPI   = 2'h1;
  localparam logic [1:0]  PR_I2C   = 2'h2;
  localparam logic [1:0]  PR_BAD   = 2'h3;

  localparam int          NUM_ENG  = 3;
  localparam int          RXD_W    = 8;
  localparam int          ADDR_W   = 8;

  // register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_RXDATA   = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h10;

  // field positions
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          IRQ_OK_BIT   = 0;
  localparam int          IRQ_ERR_BIT  = 1;
  localparam int          IRQ_DATA_BIT = 2;
  localparam int          IRQ_W        = 3;

  // values after reset
  localparam logic        CTRL_EN_RST  = 1'b1;
  localparam logic [2:0]  IRQ_MASK_RST = 3'h0;
  localparam logic [3:0]  SETTINGS_RST = 4'h0;
  localparam logic [1:0]  PROTO_RST    = 2'h0;

  // bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PAYLOAD, ST_DROP} spcfe_state_t;

endpackage : spcfe_pkg

// [rtl/spcfe_nib_shift.sv]
// serial to nibble shifter, msb first, one bit per edge while framed
`timescale 1ns/1ps
`default_nettype none
module spcfe_nib_shift (
  input  wire logic       sys_clk,    // system clock
  input  wire logic       rst,        // synchronous reset, active high
  input  wire logic       frame_en,   // framing enable, gated by ctrl
  input  wire logic       ser_in,     // serial data bit
  output logic      [3:0] nib_q,      // completed nibble
  output logic            nib_vld_q   // one-cycle pulse with nib_q
);

  logic [2:0] sh_q;
  logic [1:0] cnt_q;

  // bit counter restarts whenever the frame drops, so a torn nibble is lost
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 2'h0;
      sh_q  <= 3'h0;
    end else if (frame_en) begin
      cnt_q <= cnt_q + 2'h1;
      sh_q  <= {sh_q[1:0], ser_in};
    end else begin
      cnt_q <= 2'h0;
    end
  end

  // fourth bit completes the nibble
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nib_q     <= 4'h0;
      nib_vld_q <= 1'b0;
    end else begin
      nib_vld_q <= frame_en && (cnt_q == spcfe_pkg::NIB_LAST);
      if (frame_en && (cnt_q == spcfe_pkg::NIB_LAST)) begin
        nib_q <= {sh_q, ser_in};
      end
    end
  end

endmodule : spcfe_nib_shift
`default_nettype wire

// [rtl/spcfe_top.sv]
// command front end: nibble decode, engine routing, axi4-lite registers
//
// Overview of operation
// - host keeps frame low idle; high frame captures msb-first nibbles, one bit per edge
// - upper two bits of first nibble: 00 is read, 11 is write
// - lower two bits pick engine: 00 uart, 01 spi, 10 i2c
// - operation 10 reuses stored settings; host uses it only for writes
// - read fetches engine data and clears the data interrupt output
// - write keeps settings after a reuse flag, else loads fresh settings nibble
// - later nibbles go as payload to the chosen engine
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spcfe_top (
  input  wire logic        sys_clk,         // 250 MHz system clock
  input  wire logic        rst,             // synchronous reset, active high
  // host nibble link
  input  wire logic        frame_en,        // framing enable from host
  input  wire logic        ser_in,          // serial command/data bit
  // engine side
  input  wire logic        uart_rx_new,     // uart has new data, pulse
  input  wire logic        spi_rx_new,      // spi has new data, pulse
  input  wire logic        i2c_rx_new,      // i2c has new data, pulse
  input  wire logic [7:0]  uart_rx_data,    // uart received byte
  input  wire logic [7:0]  spi_rx_data,     // spi received byte
  input  wire logic [7:0]  i2c_rx_data,     // i2c received byte
  output logic      [2:0]  peripheral_select_out, // one-hot engine select
  output logic      [3:0]  settings_q,      // current engine settings
  output logic             settings_load_q, // pulse: fresh settings
  output logic      [3:0]  payload_q,       // payload nibble
  output logic             payload_vld_q,   // pulse: payload_q valid
  output logic             rd_strobe_q,     // pulse: data fetched
  output logic      [7:0]  rx_data_q,       // last fetched byte
  output logic             data_irq_q,      // engine data pending
  // axi4-lite slave
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [7:0]  s_axi_awaddr,    // write address
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // write byte strobes
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  output logic      [1:0]  s_axi_bresp,     // write response
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  input  wire logic [7:0]  s_axi_araddr,    // read address
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  output logic      [31:0] s_axi_rdata,     // read data
  output logic      [1:0]  s_axi_rresp,     // read response
  output logic             irq              // level interrupt
);

  // true for any offset that maps a register
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == spcfe_pkg::OFS_CTRL) || (a == spcfe_pkg::OFS_STATUS) ||
              (a == spcfe_pkg::OFS_RXDATA) || (a == spcfe_pkg::OFS_IRQ_STAT) ||
              (a == spcfe_pkg::OFS_IRQ_MASK);
  endfunction : reg_hit

  logic                     ctrl_en_q;
  logic [2:0]               irq_stat_q;
  logic [2:0]               irq_mask_q;
  logic [3:0]               nib;
  logic                     nib_vld;
  spcfe_pkg::spcfe_state_t  state_q;
  logic [1:0]               op_q;
  logic [1:0]               proto_q;
  logic                     reuse_q;
  logic [1:0]               op_f;
  logic [1:0]               pr_f;
  logic                     cmd_take;
  logic                     cmd_bad;
  logic                     any_new;
  logic                     aw_hold_q;
  logic                     w_hold_q;
  logic [7:0]               awaddr_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;
  logic                     wr_fire;
  logic                     wr_b0;

  // the ctrl enable lets software park the link without the host's help
  spcfe_nib_shift u_shift (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .frame_en  (frame_en && ctrl_en_q),
    .ser_in    (ser_in),
    .nib_q     (nib),
    .nib_vld_q (nib_vld)
  );

  // command field split
  assign op_f     = nib[3:2];
  assign pr_f     = nib[1:0];
  assign cmd_take = nib_vld && (state_q == spcfe_pkg::ST_IDLE);
  assign any_new  = uart_rx_new || spi_rx_new || i2c_rx_new;
  assign cmd_bad  = (op_f == spcfe_pkg::OP_BAD) ||
                    ((op_f != spcfe_pkg::OP_REUSE) && (pr_f == spcfe_pkg::PR_BAD));

  // frame sequencer; a dropped frame returns to idle unless it drops only in the nib_vld cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= spcfe_pkg::ST_IDLE;
    end else if (nib_vld) begin
      unique case (state_q)
        spcfe_pkg::ST_IDLE: begin
          if (cmd_bad) begin
            state_q <= spcfe_pkg::ST_DROP;
          end else if (op_f == spcfe_pkg::OP_WRITE) begin
            state_q <= spcfe_pkg::ST_SETUP;
          end else if (op_f == spcfe_pkg::OP_REUSE) begin
            state_q <= spcfe_pkg::ST_PAYLOAD;
          end else begin
            state_q <= spcfe_pkg::ST_DROP;
          end
        end
        spcfe_pkg::ST_SETUP:   state_q <= spcfe_pkg::ST_PAYLOAD;
        spcfe_pkg::ST_PAYLOAD: state_q <= spcfe_pkg::ST_PAYLOAD;
        spcfe_pkg::ST_DROP:    state_q <= spcfe_pkg::ST_DROP;
      endcase
    end else if (!(frame_en && ctrl_en_q)) begin
      state_q <= spcfe_pkg::ST_IDLE;
    end
  end

  // latched command, engine choice and reuse flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_q    <= spcfe_pkg::OP_READ;
      proto_q <= spcfe_pkg::PROTO_RST;
      reuse_q <= 1'b0;
    end else if (cmd_take && !cmd_bad) begin
      op_q    <= op_f;
      reuse_q <= (op_f == spcfe_pkg::OP_REUSE);
      if (op_f != spcfe_pkg::OP_REUSE) begin
        proto_q <= pr_f;
      end
    end
  end

  // one-hot select follows the latched protocol
  generate
    for (genvar g = 0; g < spcfe_pkg::NUM_ENG; g++) begin : g_sel
      assign peripheral_select_out[g] = (proto_q == 2'(g));
    end
  endgenerate

  // settings: only a write's second nibble replaces them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settings_q      <= spcfe_pkg::SETTINGS_RST;
      settings_load_q <= 1'b0;
    end else begin
      settings_load_q <= nib_vld && (state_q == spcfe_pkg::ST_SETUP);
      if (nib_vld && (state_q == spcfe_pkg::ST_SETUP)) begin
        settings_q <= nib;
      end
    end
  end

  // payload forwarding to the selected engine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      payload_q     <= 4'h0;
      payload_vld_q <= 1'b0;
    end else begin
      payload_vld_q <= nib_vld && (state_q == spcfe_pkg::ST_PAYLOAD);
      if (nib_vld && (state_q == spcfe_pkg::ST_PAYLOAD)) begin
        payload_q <= nib;
      end
    end
  end

  // read fetch; a new arrival in the fetch cycle keeps the flag set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_strobe_q <= 1'b0;
      rx_data_q   <= 8'h00;
      data_irq_q  <= 1'b0;
    end else begin
      rd_strobe_q <= cmd_take && !cmd_bad && (op_f == spcfe_pkg::OP_READ);
      if (cmd_take && !cmd_bad && (op_f == spcfe_pkg::OP_READ)) begin
        unique case (pr_f)
          spcfe_pkg::PR_UART: rx_data_q <= uart_rx_data;
          spcfe_pkg::PR_SPI:  rx_data_q <= spi_rx_data;
          default:            rx_data_q <= i2c_rx_data;
        endcase
      end
      if (any_new) begin
        data_irq_q <= 1'b1;
      end else if (cmd_take && !cmd_bad && (op_f == spcfe_pkg::OP_READ)) begin
        data_irq_q <= 1'b0;
      end
    end
  end

  // axi write channel holds; address and data may arrive in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_fire       = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_b0         = wr_fire && wstrb_q[0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= spcfe_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_hit(awaddr_q) ? spcfe_pkg::RESP_OKAY : spcfe_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software-written control and mask
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_en_q  <= spcfe_pkg::CTRL_EN_RST;
      irq_mask_q <= spcfe_pkg::IRQ_MASK_RST;
    end else if (wr_b0) begin
      if (awaddr_q == spcfe_pkg::OFS_CTRL) begin
        ctrl_en_q <= wdata_q[spcfe_pkg::CTRL_EN_BIT];
      end
      if (awaddr_q == spcfe_pkg::OFS_IRQ_MASK) begin
        irq_mask_q <= wdata_q[2:0];
      end
    end
  end

  // sticky events: set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_q <= 3'h0;
    end else begin
      for (int i = 0; i < spcfe_pkg::IRQ_W; i++) begin
        if (wr_b0 && (awaddr_q == spcfe_pkg::OFS_IRQ_STAT) && wdata_q[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
      if (cmd_take && !cmd_bad) begin
        irq_stat_q[spcfe_pkg::IRQ_OK_BIT] <= 1'b1;
      end
      if (cmd_take && cmd_bad) begin
        irq_stat_q[spcfe_pkg::IRQ_ERR_BIT] <= 1'b1;
      end
      if (any_new) begin
        irq_stat_q[spcfe_pkg::IRQ_DATA_BIT] <= 1'b1;
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // axi read: one outstanding, answered the edge after the address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= spcfe_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= reg_hit(s_axi_araddr) ? spcfe_pkg::RESP_OKAY : spcfe_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        spcfe_pkg::OFS_CTRL:     s_axi_rdata <= {31'h0, ctrl_en_q};
        spcfe_pkg::OFS_STATUS:   s_axi_rdata <= {24'h0, data_irq_q, reuse_q, state_q, op_q, proto_q};
        spcfe_pkg::OFS_RXDATA:   s_axi_rdata <= {24'h0, rx_data_q};
        spcfe_pkg::OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_q};
        spcfe_pkg::OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_q};
        default:                 s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks beside the logic they guard

  a_nib_framed: assert property (
    @(posedge sys_clk) disable iff (rst)
    nib_vld |-> $past(frame_en, 1) && $past(frame_en, 4))
    else $error("nibble completed without a full frame");

  a_write_decode: assert property (
    @(posedge sys_clk) disable iff (rst)
    cmd_take && !cmd_bad && (op_f == spcfe_pkg::OP_WRITE) |=> (state_q == spcfe_pkg::ST_SETUP))
    else $error("write command did not enter settings phase");

  a_route_sel: assert property (
    @(posedge sys_clk) disable iff (rst)
    cmd_take && !cmd_bad && (op_f != spcfe_pkg::OP_REUSE)
    |=> peripheral_select_out == (3'h1 << $past(pr_f)))
    else $error("engine select does not match protocol field");

  a_reuse_keep: assert property (
    @(posedge sys_clk) disable iff (rst)
    cmd_take && (op_f == spcfe_pkg::OP_REUSE)
    |=> (state_q == spcfe_pkg::ST_PAYLOAD) && $stable(settings_q) && $stable(proto_q))
    else $error("reuse command altered stored settings");

  a_read_clear: assert property (
    @(posedge sys_clk) disable iff (rst)
    cmd_take && !cmd_bad && (op_f == spcfe_pkg::OP_READ) && !any_new
    |=> rd_strobe_q && !data_irq_q ##1 !rd_strobe_q)
    else $error("read did not fetch once and clear interrupt");

  a_fresh_load: assert property (
    @(posedge sys_clk) disable iff (rst)
    nib_vld && (state_q == spcfe_pkg::ST_SETUP)
    |=> settings_load_q && (settings_q == $past(nib)))
    else $error("fresh settings nibble not loaded");

  a_payload_fwd: assert property (
    @(posedge sys_clk) disable iff (rst)
    nib_vld && (state_q == spcfe_pkg::ST_PAYLOAD)
    |=> payload_vld_q && (payload_q == $past(nib)))
    else $error("payload nibble not forwarded");

  a_bad_ignored: assert property (
    @(posedge sys_clk) disable iff (rst)
    cmd_take && cmd_bad
    |=> (state_q == spcfe_pkg::ST_DROP) && $stable(settings_q) && $stable(proto_q) && !rd_strobe_q)
    else $error("undefined command was acted on");

endmodule : spcfe_top
`default_nettype wire

// [verification/spcfe_host_model.sv]
// host model: drives the framed nibble-serial command stream
`timescale 1ns/1ps
`default_nettype none
module spcfe_host_model (
  input  wire logic sys_clk,  // system clock
  output logic      frame_en, // framing enable
  output logic      ser_in    // serial bit
);
  logic busy;

  initial begin
    frame_en = 1'b0;
    ser_in   = 1'b0;
    busy     = 1'b0;
  end

  // released line toggles so a stale bit never passes for data
  always @(posedge sys_clk) begin
    if (!busy)
      ser_in <= ~ser_in;
  end

  // reuse code only ever sent by write scenarios
  task send(input logic [15:0] bits, input int n);
    busy = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk);
      frame_en <= 1'b1;
      ser_in   <= bits[i];
    end
    @(posedge sys_clk);
    frame_en <= 1'b0;
    busy = 1'b0;
    @(posedge sys_clk);
  endtask : send
endmodule : spcfe_host_model
`default_nettype wire

// [verification/test_spcfe_top.sv]
// self-checking bench of the command front end
`timescale 1ns/1ps
`default_nettype none
module test_spcfe_top;
  logic        sys_clk, rst, frame_en, ser_in, u_new, s_new, i_new;
  logic [7:0]  u_dat, s_dat, i_dat, rx_data_q, awaddr, araddr;
  logic [2:0]  sel;
  logic [3:0]  settings_q, payload_q, wstrb;
  logic        settings_load_q, payload_vld_q, rd_strobe_q, data_irq_q, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          n_mismatch, compares, n_load, n_rd, b;
  logic [3:0]  pay_q[$];

  spcfe_top spcfe_top_i (.sys_clk(sys_clk), .rst(rst), .frame_en(frame_en), .ser_in(ser_in),
    .uart_rx_new(u_new), .spi_rx_new(s_new), .i2c_rx_new(i_new), .uart_rx_data(u_dat),
    .spi_rx_data(s_dat), .i2c_rx_data(i_dat), .peripheral_select_out(sel), .settings_q(settings_q),
    .settings_load_q(settings_load_q), .payload_q(payload_q), .payload_vld_q(payload_vld_q),
    .rd_strobe_q(rd_strobe_q), .rx_data_q(rx_data_q), .data_irq_q(data_irq_q),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .irq(irq));

  spcfe_host_model host_i (.sys_clk(sys_clk), .frame_en(frame_en), .ser_in(ser_in));

  // clock, 4 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // collect the one-cycle output pulses
  always @(posedge sys_clk) begin
    if (!rst && payload_vld_q) pay_q.push_back(payload_q);
    if (!rst && settings_load_q) n_load++;
    if (!rst && rd_strobe_q) n_rd++;
  end

  task end_sim;
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task tmo;
    n_mismatch++;
    $display("FAIL %0t bus answer never came", $time);
    end_sim();
  endtask : tmo

  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // address and data offered together, each released once taken
  task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge sys_clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (k == 50) tmo();
    rs = bresp;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (k == 50) tmo();
    v  = rdata;
    rs = rresp;
  endtask : axi_rd

  task t_reset;
    chk(sel, 3'h1, "select after reset");
    chk(settings_q, 4'h0, "settings after reset");
    chk(irq, 1'b0, "irq after reset");
    axi_rd(spcfe_pkg::OFS_CTRL, d, r);
    chk(d, 32'h1, "ctrl reset value");
    axi_rd(spcfe_pkg::OFS_IRQ_MASK, d, r);
    chk(d, 32'h0, "mask reset value");
    $display("test reset done");
  endtask : t_reset

  // write to spi: settings nibble then two payload nibbles
  task t_write;
    pay_q.delete();
    b = n_load;
    host_i.send(16'hda69, 16);
    cyc(4);
    chk(sel, 3'h2, "spi select");
    chk(n_load - b, 32'h1, "fresh settings load");
    chk(settings_q, 4'ha, "settings value");
    chk(pay_q.size(), 32'h2, "payload count");
    chk({pay_q[0], pay_q[1]}, 32'h69, "payload order");
    $display("test write done");
  endtask : t_write

  // reuse code: protocol bits ignored, payload follows at once
  task t_reuse;
    pay_q.delete();
    b = n_load;
    host_i.send(16'h0083, 8);
    cyc(4);
    chk(sel, 3'h2, "reuse keeps engine");
    chk(n_load - b, 32'h0, "reuse loads nothing");
    chk(settings_q, 4'ha, "reuse keeps settings");
    chk(pay_q.size(), 32'h1, "reuse payload count");
    chk(pay_q[0], 4'h3, "reuse payload");
    axi_rd(spcfe_pkg::OFS_STATUS, d, r);
    chk(d, 32'h49, "status after reuse");
    $display("test reuse done");
  endtask : t_reuse

  task t_protos;
    for (int p = 0; p < 3; p++) begin
      host_i.send({8'h00, 2'h3, p[1:0], 4'h5}, 8);
      cyc(4);
      chk(sel, 3'h1 << p, "engine select");
      chk(settings_q, 4'h5, "settings per engine");
    end
    $display("test protocols done");
  endtask : t_protos

  // undefined codes must leave select, settings and output pulses as they were
  task t_bad;
    pay_q.delete();
    b = n_load + n_rd;
    host_i.send(16'h005c, 8);
    host_i.send(16'h0f3a, 12);
    host_i.send(16'h0003, 4);
    cyc(4);
    chk(sel, 3'h4, "select kept");
    chk(settings_q, 4'h5, "settings kept");
    chk(n_load + n_rd - b, 32'h0, "no action");
    chk(pay_q.size(), 32'h0, "no payload");
    $display("test bad codes done");
  endtask : t_bad

  task t_read;
    @(posedge sys_clk);
    i_new <= 1'b1;
    @(posedge sys_clk);
    i_new <= 1'b0;
    cyc(2);
    chk(data_irq_q, 1'b1, "data pending");
    b = n_rd;
    host_i.send(16'h0002, 4);
    cyc(4);
    chk(n_rd - b, 32'h1, "one fetch");
    chk(rx_data_q, 8'h5c, "i2c byte fetched");
    chk(data_irq_q, 1'b0, "interrupt cleared");
    chk(sel, 3'h4, "read select");
    axi_rd(spcfe_pkg::OFS_RXDATA, d, r);
    chk(d, 32'h5c, "rxdata register");
    // the other two engines must reach the fetch mux as well
    for (int p = 0; p < 2; p++) begin
      host_i.send({12'h000, 2'h0, p[1:0]}, 4);
      cyc(4);
      chk(rx_data_q, (p == 0) ? u_dat : s_dat, "engine byte fetched");
    end
    $display("test read done");
  endtask : t_read

  // rejected command raises the masked interrupt, w1c clears it
  task t_irq;
    axi_wr(spcfe_pkg::OFS_IRQ_STAT, 32'h7, r);
    axi_wr(spcfe_pkg::OFS_IRQ_MASK, 32'h2, r);
    cyc(2);
    chk(irq, 1'b0, "irq quiet");
    host_i.send(16'h0005, 4);
    cyc(4);
    chk(irq, 1'b1, "irq on reject");
    axi_rd(spcfe_pkg::OFS_IRQ_STAT, d, r);
    chk(d, 32'h2, "reject status");
    axi_wr(spcfe_pkg::OFS_IRQ_STAT, 32'h2, r);
    chk(r, spcfe_pkg::RESP_OKAY, "write response");
    cyc(1);
    chk(irq, 1'b0, "irq cleared");
    axi_rd(8'h40, d, r);
    chk(r, spcfe_pkg::RESP_SLVERR, "unmapped response");
    chk(d, 32'h0, "unmapped data");
    $display("test interrupt done");
  endtask : t_irq

  // software parks the link: a full write frame must change nothing
  task t_park;
    pay_q.delete();
    b = n_load;
    axi_wr(spcfe_pkg::OFS_CTRL, 32'h0, r);
    host_i.send(16'hc3f6, 16);
    cyc(4);
    chk(n_load - b, 32'h0, "parked link loads nothing");
    chk(sel, 3'h2, "parked link keeps engine");
    chk(settings_q, 4'h5, "parked link keeps settings");
    chk(pay_q.size(), 32'h0, "parked link no payload");
    axi_wr(spcfe_pkg::OFS_CTRL, 32'h1, r);
    $display("test park done");
  endtask : t_park

  initial begin
    rst = 1'b1;
    {u_new, s_new, i_new, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    u_dat = 8'h11;
    s_dat = 8'h22;
    i_dat = 8'h5c;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {n_mismatch, compares, n_load, n_rd} = 128'h0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_write();
    t_reuse();
    t_protos();
    t_bad();
    t_read();
    t_irq();
    t_park();
    end_sim();
  end
endmodule : test_spcfe_top
`default_nettype wire
